// file: hdl/field_sup_pkg.sv
// Constants shared by the excitation field supervision block.
// Assumes a 40 MHz supervision clock; settings are unsigned integers in step units.
package field_sup_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 40000000;
  // Open-field delay: 5 ms per step, default 3.000 s
  localparam int unsigned OF_STEP_US = 5000;
  localparam int unsigned OF_STEP_CYC = (CLK_HZ / 1000000) * OF_STEP_US;
  localparam logic [11:0] OF_DELAY_RST = 12'h258;
  // Thresholds in hundredths: high 1.00, low 0.10
  localparam logic [11:0] CS_HIGH_RST = 12'h064;
  localparam logic [11:0] IF_LOW_RST = 12'h00a;
  // Temperature alarm level in whole units, default 100
  localparam logic [7:0] TEMP_ALARM_RST = 8'h64;
  // Breaker timing: 0.1 s per step; inverter 1.0 s, trip 0.5 s
  localparam int unsigned TENTH_MS = 100;
  localparam int unsigned TENTH_CYC = (CLK_HZ / 1000) * TENTH_MS;
  localparam logic [13:0] INV_TIME_RST = 14'h000a;
  localparam logic [13:0] BRK_TIME_RST = 14'h0005;
  // Ramp rate in hundredths p.u./s; default 0.02, output in 1e-4 p.u.
  localparam logic [6:0] RAMP_RATE_RST = 7'h02;
  // One ramp tick per 10 ms; at rate r hundredths/s the output moves r units of 1e-4 p.u. per tick
  localparam int unsigned RAMP_TICK_MS = 10;
  localparam int unsigned RAMP_TICK_CYC = (CLK_HZ / 1000) * RAMP_TICK_MS;
  // Breaker trip sequence
  typedef enum logic [1:0] {BRK_IDLE, BRK_INVERT, BRK_OPENING, BRK_DONE} brk_state_t;
endpackage

// file: hdl/field_sup.sv
// Excitation field supervision: open field trip, switch temperature alarm,
// internal field breaker trip sequence and open-loop control ramp.
// Assumes all inputs synchronous to REF_CLK and settings held stable.
// Overview of operation
// - Open-field monitoring enable, default disabled
// - Open field when signal high, current low
// - Persisting condition trips rectifier, stops excitation
// - Open-field delay in 5 ms steps, 3 s
// - Control-signal high threshold, hundredths, default 1
// - Field-current low threshold, not exceeded, 0.10
// - Temperature above level raises alarm, default 100
// - Temperature supervision is always active
// - Breaker off with machine breaker open de-excites
// - Open field breaker after inverter-mode time
// - Event when breaker not open in time
// - Trip-to-open delay, tenth seconds, default 0.5
// - Open-loop option ramps control at set rate
`timescale 1ns/10ps
`default_nettype none
module field_sup
  import field_sup_pkg::*;
#(
  parameter int unsigned OF_STEP_CYCLES = field_sup_pkg::OF_STEP_CYC,
  parameter int unsigned TENTH_CYCLES = field_sup_pkg::TENTH_CYC,
  parameter int unsigned RAMP_CYCLES = field_sup_pkg::RAMP_TICK_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OPEN_FIELD_MON_EN,
  input wire logic [11:0] OF_DELAY_STEPS,
  input wire logic [11:0] CTRL_HIGH_THR,
  input wire logic [11:0] FIELD_LOW_THR,
  input wire logic [11:0] CTRL_SIGNAL,
  input wire logic [11:0] FIELD_CURRENT,
  input wire logic [7:0] TEMP_ALARM_LEVEL,
  input wire logic [7:0] SWITCH_TEMP,
  input wire logic INT_BRK_TRIP_EN,
  input wire logic MACHINE_BRK_OPEN,
  input wire logic FIELD_BRK_OFF_CMD,
  input wire logic FIELD_BRK_IS_OPEN,
  input wire logic [13:0] INV_TIME_STEPS,
  input wire logic [13:0] BRK_TIME_STEPS,
  input wire logic OPEN_LOOP_REFERENCE_OPTION,
  input wire logic RAMP_UP,
  input wire logic RAMP_DOWN,
  input wire logic [6:0] RAMP_RATE,
  output logic OPEN_FIELD_ACTIVE,
  output logic RECT_TRIP,
  output logic TEMP_ALARM,
  output logic DEEXCITE,
  output logic FIELD_BRK_TRIP,
  output logic BRK_FAIL_EVENT,
  output logic [15:0] RAMP_CTRL
);
  import field_sup_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Open field detection
  ////////////////////////////////////////////////////////////////////////////

  // Condition decode; current equal to the low threshold still counts
  wire cond_open = (CTRL_SIGNAL > CTRL_HIGH_THR) && (FIELD_CURRENT <= FIELD_LOW_THR);
  wire of_run = OPEN_FIELD_MON_EN && cond_open;
  logic [31:0] of_pre_q;
  logic [11:0] of_steps_q;
  logic trip_q;
  wire of_pre_wrap = (of_pre_q == OF_STEP_CYCLES - 1);
  wire of_expired = (of_steps_q >= OF_DELAY_STEPS);

  // Trip latches until reset so excitation stays stopped after a fault
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      of_pre_q <= '0;
      of_steps_q <= '0;
      trip_q <= 1'b0;
    end else if (CLK_EN) begin
      if (!of_run) begin
        of_pre_q <= '0;
        of_steps_q <= '0;
      end else if (of_expired) begin
        trip_q <= 1'b1;
      end else if (of_pre_wrap) begin
        of_pre_q <= '0;
        of_steps_q <= of_steps_q + 12'h001;
      end else begin
        of_pre_q <= of_pre_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch temperature alarm, no enable on purpose
  ////////////////////////////////////////////////////////////////////////////

  logic temp_q;
  logic active_q;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      temp_q <= 1'b0;
      active_q <= 1'b0;
    end else if (CLK_EN) begin
      temp_q <= (SWITCH_TEMP > TEMP_ALARM_LEVEL);
      active_q <= of_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal field breaker trip sequence
  ////////////////////////////////////////////////////////////////////////////

  brk_state_t st_q, st_d;
  logic [31:0] tpre_q;
  logic [13:0] tsteps_q;
  logic ev_q;
  wire start_seq = INT_BRK_TRIP_EN && MACHINE_BRK_OPEN && FIELD_BRK_OFF_CMD;
  wire tick = (tpre_q == TENTH_CYCLES - 1);
  wire inv_done = (tsteps_q >= INV_TIME_STEPS);
  wire brk_late = (tsteps_q >= BRK_TIME_STEPS);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      BRK_IDLE: begin
        if (start_seq) st_d = BRK_INVERT;
      end
      BRK_INVERT: begin
        if (inv_done) st_d = BRK_OPENING;
      end
      BRK_OPENING: begin
        if (FIELD_BRK_IS_OPEN || brk_late) st_d = BRK_DONE;
      end
      BRK_DONE: begin
        if (!FIELD_BRK_OFF_CMD) st_d = BRK_IDLE;
      end
      default: st_d = BRK_IDLE;
    endcase
  end

  // Time base restarts on each state change so each phase counts from zero
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= BRK_IDLE;
      tpre_q <= '0;
      tsteps_q <= '0;
      ev_q <= 1'b0;
    end else if (CLK_EN) begin
      st_q <= st_d;
      ev_q <= (st_q == BRK_OPENING) && !FIELD_BRK_IS_OPEN && brk_late;
      if (st_d != st_q || st_q == BRK_IDLE || st_q == BRK_DONE) begin
        tpre_q <= '0;
        tsteps_q <= '0;
      end else if (tick) begin
        tpre_q <= '0;
        tsteps_q <= tsteps_q + 14'h0001;
      end else begin
        tpre_q <= tpre_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-loop control ramp (test use only)
  ////////////////////////////////////////////////////////////////////////////

  // Output in 1e-4 p.u.; each 10 ms tick moves rate hundredths/s by rate*1e-4
  logic [31:0] rpre_q;
  logic [15:0] ramp_q;
  wire rtick = (rpre_q == RAMP_CYCLES - 1);
  wire [15:0] step = {9'h000, RAMP_RATE};
  wire [16:0] up_sum = {1'b0, ramp_q} + {1'b0, step};
  wire [15:0] up_val = up_sum[16] ? 16'hffff : up_sum[15:0];
  wire [15:0] dn_val = (ramp_q < step) ? 16'h0000 : ramp_q - step;

  // Saturating ramp; holds when the option is deselected
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rpre_q <= '0;
      ramp_q <= '0;
    end else if (CLK_EN) begin
      rpre_q <= rtick ? 32'h0 : rpre_q + 32'h1;
      if (OPEN_LOOP_REFERENCE_OPTION && rtick) begin
        if (RAMP_UP && !RAMP_DOWN) ramp_q <= up_val;
        else if (RAMP_DOWN && !RAMP_UP) ramp_q <= dn_val;
      end
    end
  end

  // Outputs
  assign OPEN_FIELD_ACTIVE = active_q;
  assign RECT_TRIP = trip_q;
  assign TEMP_ALARM = temp_q;
  assign DEEXCITE = (st_q == BRK_INVERT) || (st_q == BRK_OPENING);
  assign FIELD_BRK_TRIP = (st_q == BRK_OPENING) || (st_q == BRK_DONE);
  assign BRK_FAIL_EVENT = ev_q;
  assign RAMP_CTRL = ramp_q;
endmodule
`default_nettype wire

// file: verif/brk_model.sv
// Field breaker contact model at the far side of the trip sequence.
// Assumes trip is a level from the supervision block, sampled on clk.
`timescale 1ns/10ps
`default_nettype none
module brk_model (
  input wire logic clk,
  input wire logic trip,
  input wire logic stuck,
  output logic is_open
);
  logic [1:0] cnt_q = 2'h0;
  // Contact opens three cycles into a trip; a jammed breaker never reports open
  always_ff @(posedge clk) begin
    if (!trip) begin
      cnt_q <= 2'h0;
    end else if (cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  assign is_open = !stuck && cnt_q == 2'h3;
endmodule
`default_nettype wire

// file: verif/field_sup_chk.sv
// Port checker for field_sup: temperature, trips, breaker sequence, ramp.
// Assumes it is bound to field_sup and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module field_sup_chk (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OPEN_FIELD_MON_EN,
  input wire logic [7:0] TEMP_ALARM_LEVEL,
  input wire logic [7:0] SWITCH_TEMP,
  input wire logic INT_BRK_TRIP_EN,
  input wire logic MACHINE_BRK_OPEN,
  input wire logic FIELD_BRK_OFF_CMD,
  input wire logic FIELD_BRK_IS_OPEN,
  input wire logic OPEN_LOOP_REFERENCE_OPTION,
  input wire logic RECT_TRIP,
  input wire logic TEMP_ALARM,
  input wire logic DEEXCITE,
  input wire logic FIELD_BRK_TRIP,
  input wire logic BRK_FAIL_EVENT,
  input wire logic [15:0] RAMP_CTRL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // Idle is the only state with both breaker outputs low
  wire logic idle = !DEEXCITE && !FIELD_BRK_TRIP;
  wire logic go = INT_BRK_TRIP_EN && MACHINE_BRK_OPEN && FIELD_BRK_OFF_CMD;
  property p_temp; CLK_EN && $past(RESET_N)
    |=> TEMP_ALARM == $past(SWITCH_TEMP > TEMP_ALARM_LEVEL); endproperty
  a_temp: assert property (p_temp) else $error("temp alarm wrong");
  property p_rect_hold; RECT_TRIP |=> RECT_TRIP; endproperty
  a_rect_hold: assert property (p_rect_hold) else $error("trip dropped");
  property p_rect_en; $rose(RECT_TRIP) |-> $past(OPEN_FIELD_MON_EN); endproperty
  a_rect_en: assert property (p_rect_en) else $error("trip while disabled");
  property p_go; idle && CLK_EN && go |=> DEEXCITE; endproperty
  a_go: assert property (p_go) else $error("no de-excite");
  property p_stay; idle && !go |=> idle; endproperty
  a_stay: assert property (p_stay) else $error("spurious start");
  property p_order; $rose(FIELD_BRK_TRIP) |-> $past(DEEXCITE) && DEEXCITE; endproperty
  a_order: assert property (p_order) else $error("trip before de-excite");
  property p_fail; BRK_FAIL_EVENT |-> $past(FIELD_BRK_TRIP && !FIELD_BRK_IS_OPEN)
    ##1 !BRK_FAIL_EVENT; endproperty
  a_fail: assert property (p_fail) else $error("bad fail event");
  property p_ramp; !OPEN_LOOP_REFERENCE_OPTION |=> $stable(RAMP_CTRL); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp moved");
endmodule
bind field_sup field_sup_chk field_sup_chk_inst (.*);
`default_nettype wire

// file: verif/field_sup_tb.sv
// Bench for field_sup: temperature, open field, breaker trip and ramp.
// Assumes prescalers shortened to 4 cycles and the breaker model as far side.
`timescale 1ns/10ps
`default_nettype none
module field_sup_tb;
  import field_sup_pkg::*;
  logic clk = 0, rst_n = 0, mon = 0, ben = 0, mopen = 0, off = 0, opt = 0, up = 0, dn = 0;
  logic en = 1;
  logic stuck = 0, isopen, ofa, rtrip, talm, deex, btrip, bfail;
  logic [11:0] ctrl = 12'h000, cur = 12'h000;
  logic [7:0] temp = 8'h00, lvl = TEMP_ALARM_RST;
  logic [13:0] btime = 14'h0002;
  logic [15:0] ramp;
  int err_count = 0, compares = 0, nfail = 0;
  field_sup #(.OF_STEP_CYCLES(4), .TENTH_CYCLES(4), .RAMP_CYCLES(4)) field_sup_inst (
    .REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .OPEN_FIELD_MON_EN(mon),
    .OF_DELAY_STEPS(12'h002), .CTRL_HIGH_THR(CS_HIGH_RST), .FIELD_LOW_THR(IF_LOW_RST),
    .CTRL_SIGNAL(ctrl), .FIELD_CURRENT(cur), .TEMP_ALARM_LEVEL(lvl), .SWITCH_TEMP(temp),
    .INT_BRK_TRIP_EN(ben), .MACHINE_BRK_OPEN(mopen), .FIELD_BRK_OFF_CMD(off),
    .FIELD_BRK_IS_OPEN(isopen), .INV_TIME_STEPS(14'h0001), .BRK_TIME_STEPS(btime),
    .OPEN_LOOP_REFERENCE_OPTION(opt), .RAMP_UP(up), .RAMP_DOWN(dn), .RAMP_RATE(RAMP_RATE_RST),
    .OPEN_FIELD_ACTIVE(ofa), .RECT_TRIP(rtrip), .TEMP_ALARM(talm), .DEEXCITE(deex),
    .FIELD_BRK_TRIP(btrip), .BRK_FAIL_EVENT(bfail), .RAMP_CTRL(ramp));
  brk_model brk_model_inst (.clk(clk), .trip(btrip), .stuck(stuck), .is_open(isopen));
  initial forever #12.5 clk = ~clk;
  // Failure pulses last one cycle, so count them instead of polling
  always @(posedge clk) if (bfail === 1'b1) nfail++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait on rtrip (0), btrip (1) or a counted failure (2)
  task automatic wt(input int sel, input int n);
    logic s;
    s = 1'b0;
    for (int i = 0; i < n && s !== 1'b1; i++) begin
      cyc(1);
      s = sel == 0 ? rtrip : sel == 1 ? btrip : nfail != 0;
    end
    if (s !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      print_verdict();
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_temp;
    temp = TEMP_ALARM_RST;
    cyc(2);
    chk(talm, 16'h0);
    temp = TEMP_ALARM_RST + 8'h01;
    cyc(2);
    chk(talm, 16'h1);
    lvl = 8'hc8;
    cyc(2);
    chk(talm, 16'h0);
    $display("t_temp done");
  endtask
  // Condition must hold unbroken for the whole delay before a trip
  task automatic t_open;
    mon = 1;
    ctrl = CS_HIGH_RST;
    cyc(20);
    chk({ofa, rtrip}, 16'h0);
    ctrl = CS_HIGH_RST + 12'h001;
    cur = IF_LOW_RST + 12'h001;
    cyc(20);
    chk({ofa, rtrip}, 16'h0);
    mon = 0;
    cur = IF_LOW_RST;
    cyc(20);
    chk({ofa, rtrip}, 16'h0);
    mon = 1;
    cyc(6);
    chk(ofa, 16'h1);
    cur = 12'h0ff;
    cyc(1);
    cur = IF_LOW_RST;
    cyc(7);
    chk(rtrip, 16'h0);
    wt(0, 5);
    mon = 0;
    $display("t_open done");
  endtask
  task automatic t_brk;
    stuck = 1;
    mopen = 1;
    off = 1;
    cyc(4);
    chk(deex, 16'h0);
    ben = 1;
    cyc(2);
    chk({deex, btrip}, 16'h2);
    wt(1, 8);
    wt(2, 16);
    off = 0;
    stuck = 0;
    btime = 14'h0003;
    cyc(2);
    off = 1;
    wt(1, 12);
    cyc(20);
    chk(nfail[15:0], 16'h1);
    off = 0;
    $display("t_brk done");
  endtask
  // Forty edges hold exactly ten ramp ticks whatever the tick phase
  task automatic t_ramp;
    opt = 1;
    up = 1;
    cyc(40);
    up = 0;
    chk(ramp, 16'(RAMP_RATE_RST) * 16'h000a);
    en = 0;
    up = 1;
    cyc(8);
    chk(ramp, 16'(RAMP_RATE_RST) * 16'h000a);
    en = 1;
    up = 0;
    dn = 1;
    cyc(60);
    chk(ramp, 16'h0000);
    opt = 0;
    dn = 0;
    up = 1;
    cyc(20);
    chk(ramp, 16'h0000);
    $display("t_ramp done");
  endtask
  initial begin
    cyc(6);
    rst_n = 1;
    t_temp();
    t_open();
    t_brk();
    t_ramp();
    print_verdict();
  end
endmodule
`default_nettype wire
